// ==== logic/srps_defs.svh ====
/*
 * Constants for the serial ROM port pin control block: strap encodings,
 * clock-rate figures, card power field positions and link timing.
 * Assumes it is included by bare name from the package and design modules.
 */
`ifndef SRPS_DEFS_SVH
`define SRPS_DEFS_SVH

// Functional notes
// - In reset, data pin floats with pull-down.
// - Reset release latches the speed strap level.
// - Then pin becomes data output, pull-down off.
// - Strap 0 selects 30 MHz, 1 selects 60.
// - Strap 1: data pin floats in suspend.
// - Strap 0: data pin driven low in suspend.
// - EEPROM mode uses data pin as serial data.
// - ROM answers on data-in pin, weak pull-down.
// - General purpose pin is output only.
// - Card power bits 0..3 drive the FET.
// - Active-low ROM select, high in power-down.
// - ROM clock driven low during reset.

// Width of one serial transfer unit.
`define SRPS_BYTE_W 8
// Strap levels and the clock rates they select, in MHz.
`define SRPS_STRAP_SLOW 1'b0
`define SRPS_STRAP_FAST 1'b1
`define SRPS_RATE_SLOW_MHZ 30
`define SRPS_RATE_FAST_MHZ 60
// Card power configuration register index and its FET field.
`define SRPS_CARD_PWR_REG 8'ha5
`define SRPS_CARD_PWR_LSB 0
`define SRPS_CARD_PWR_MSB 3
`define SRPS_CARD_PWR_W (`SRPS_CARD_PWR_MSB - `SRPS_CARD_PWR_LSB + 1)
// Least reset width expected from the system, and its count in 8 ns cycles.
`define SRPS_CLK_NS 8
`define SRPS_RESET_MIN_NS 1000
`define SRPS_RESET_MIN_CYC ((`SRPS_RESET_MIN_NS + `SRPS_CLK_NS - 1) / `SRPS_CLK_NS)
// Link cycles between a rising ROM clock and the synchronised data-in bit.
`define SRPS_SAMPLE_LAG 2

`endif

// ==== logic/srps_link_shift.sv ====
/*
 * Bit engine on the link clock: shifts one byte out MSB first and one byte
 * in, with a toggle handshake to the core clock domain.
 * Assumes tx_data is held stable from a request toggle until its ack, and
 * that link_reset is already synchronous to link_clk.
 */
`include "srps_defs.svh"

module srps_link_shift #(
    parameter int BYTE_W = `SRPS_BYTE_W
) (
    input wire logic link_clk,
    input wire logic link_reset,
    input wire logic req_toggle,
    input wire logic [BYTE_W-1:0] tx_data,
    input wire logic rom_data_in,
    output logic ack_toggle,
    output logic [BYTE_W-1:0] rx_data,
    output logic link_sclk,
    output logic link_dout
);
    import srps_pkg::*;

    localparam int CNT_W = $clog2(BYTE_W);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(BYTE_W - 1);

    srps_link_state_t state;
    logic req_s;
    logic din_s;
    logic req_seen;
    logic [BYTE_W-1:0] tx_shift;
    logic [BYTE_W-1:0] rx_shift;
    logic [CNT_W-1:0] bit_cnt;
    logic [`SRPS_SAMPLE_LAG-1:0] samp_pipe;
    wire start = req_s ^ req_seen;

    // Request toggle and returned data both come from outside this domain.
    srps_sync #(.WIDTH(2)) u_sync (
        .clk(link_clk),
        .d({req_toggle, rom_data_in}),
        .q({req_s, din_s})
    );

    // Sample strobes follow each rising ROM clock by the synchroniser lag.
    always_ff @(posedge link_clk)
    begin
        if (link_reset)
            samp_pipe <= '0;
        else
            samp_pipe <= {samp_pipe[`SRPS_SAMPLE_LAG-2:0], state == SRPS_LINK_HIGH};
    end

    // Read data from the ROM is gathered MSB first.
    always_ff @(posedge link_clk)
    begin
        if (link_reset)
            rx_shift <= '0;
        else if (samp_pipe[`SRPS_SAMPLE_LAG-1])
            rx_shift <= {rx_shift[BYTE_W-2:0], din_s};
    end

    // Bit engine: low phase puts data out, high phase lets the ROM sample it.
    always_ff @(posedge link_clk)
    begin
        if (link_reset)
        begin
            state <= SRPS_LINK_IDLE;
            req_seen <= 1'b0;
            ack_toggle <= 1'b0;
            rx_data <= '0;
            tx_shift <= '0;
            bit_cnt <= '0;
            link_sclk <= 1'b0;
            link_dout <= 1'b0;
        end
        else
        begin
            case (state)
                SRPS_LINK_IDLE:
                begin
                    if (start)
                    begin
                        req_seen <= req_s;
                        tx_shift <= {tx_data[BYTE_W-2:0], 1'b0};
                        link_dout <= tx_data[BYTE_W-1];
                        bit_cnt <= '0;
                        state <= SRPS_LINK_LOW;
                    end
                end
                SRPS_LINK_LOW:
                begin
                    link_sclk <= 1'b1;
                    state <= SRPS_LINK_HIGH;
                end
                SRPS_LINK_HIGH:
                begin
                    link_sclk <= 1'b0;
                    if (bit_cnt == LAST_BIT)
                        state <= SRPS_LINK_DRAIN;
                    else
                    begin
                        link_dout <= tx_shift[BYTE_W-1];
                        tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
                        bit_cnt <= bit_cnt + 1'b1;
                        state <= SRPS_LINK_LOW;
                    end
                end
                SRPS_LINK_DRAIN:
                begin
                    if (samp_pipe == '0)
                    begin
                        rx_data <= rx_shift;
                        ack_toggle <= ~ack_toggle;
                        state <= SRPS_LINK_IDLE;
                    end
                end
                default:
                    state <= SRPS_LINK_IDLE;
            endcase
        end
    end
endmodule : srps_link_shift

// ==== logic/srps_pkg.sv ====
/*
 * Types shared by the serial ROM port pin control modules.
 * Assumes srps_defs.svh is reachable on the include path.
 */
`include "srps_defs.svh"

package srps_pkg;

    // One pad driver: the value driven and its output enable.
    typedef struct packed {
        logic out;
        logic oe;
    } srps_pin_t;

    // Same-clock control levels from the surrounding controller.
    typedef struct packed {
        logic suspend;
        logic eeprom_mode;
        logic select_req;
    } srps_port_cfg_t;

    typedef logic [`SRPS_BYTE_W-1:0] srps_byte_t;

    // Use of the shared data-out pad.
    typedef enum logic [4:0] {
        SRPS_PIN_RESET = 5'b00001,
        SRPS_PIN_SPI = 5'b00010,
        SRPS_PIN_I2C = 5'b00100,
        SRPS_PIN_SUSP_Z = 5'b01000,
        SRPS_PIN_SUSP_LOW = 5'b10000
    } srps_pin_mode_t;

    // Bit engine states on the link clock.
    typedef enum logic [3:0] {
        SRPS_LINK_IDLE = 4'b0001,
        SRPS_LINK_LOW = 4'b0010,
        SRPS_LINK_HIGH = 4'b0100,
        SRPS_LINK_DRAIN = 4'b1000
    } srps_link_state_t;

endpackage : srps_pkg

// ==== logic/srps_rom_port.sv ====
/*
 * Serial ROM port pin control: speed strap capture on the shared data-out
 * pad, pad use by mode, ROM select and clock, byte transfers over the link,
 * general purpose output and card power FET drive.
 * Assumes reset is synchronous to clk and held by the system long enough,
 * and that link_clk is a free-running clock at the rate rom_speed_fast asks.
 */
`include "srps_defs.svh"

module srps_rom_port #(
    parameter int BYTE_W = `SRPS_BYTE_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    input srps_pkg::srps_port_cfg_t cfg,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [BYTE_W-1:0] tx_data,
    output logic rx_valid,
    output logic [BYTE_W-1:0] rx_data,
    input wire logic eeprom_sda_low,
    output logic eeprom_serial_data,
    input wire logic rom_speed_strap,
    output srps_pkg::srps_pin_t data_pin,
    output logic data_pin_pulldown,
    input wire logic rom_data_in,
    output logic rom_data_in_pulldown,
    output logic rom_clock,
    output logic rom_select_n,
    output logic rom_speed_fast,
    output logic strap_valid,
    input wire logic gpo_value,
    output logic general_output_pin,
    input wire logic [7:0] card_power_config,
    output logic [`SRPS_CARD_PWR_W-1:0] card_power_fet,
    output logic card_power_drive
);
    import srps_pkg::*;

    logic pad_s;
    logic reset_q;
    logic strap;
    logic busy;
    logic req_toggle;
    logic ack_seen;
    logic ack_s;
    logic link_reset;
    logic link_ack;
    logic link_sclk;
    logic link_dout;
    logic [BYTE_W-1:0] tx_hold;
    logic [BYTE_W-1:0] link_rx;
    srps_pin_mode_t pin_mode;

    // The pad input passes two flops before strap or I2C logic reads it.
    srps_sync #(.WIDTH(1)) u_pad_sync (
        .clk(clk),
        .d(rom_speed_strap),
        .q(pad_s)
    );

    // Ack toggle from the link domain is synchronised likewise.
    srps_sync #(.WIDTH(1)) u_ack_sync (
        .clk(clk),
        .d(link_ack),
        .q(ack_s)
    );

    // Reset reaches the link domain through its own synchroniser.
    srps_sync #(.WIDTH(1)) u_reset_sync (
        .clk(link_clk),
        .d(reset),
        .q(link_reset)
    );

    // Delayed reset marks the first cycle after release.
    always_ff @(posedge clk)
    begin
        reset_q <= reset;
    end

    wire release_edge = reset_q & ~reset;

    // Strap is latched once at release and then held until reset returns.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            strap <= `SRPS_STRAP_SLOW;
            strap_valid <= 1'b0;
        end
        else if (release_edge)
        begin
            strap <= pad_s;
            strap_valid <= 1'b1;
        end
    end

    // Strap picks the port clock rate for the clock generator.
    assign rom_speed_fast = strap_valid & (strap == `SRPS_STRAP_FAST);

    // Pad use is chosen by reset, strap, suspend and EEPROM mode in order.
    assign pin_mode = (reset | ~strap_valid) ? SRPS_PIN_RESET :
                      cfg.suspend ? ((strap == `SRPS_STRAP_FAST) ? SRPS_PIN_SUSP_Z
                                                                 : SRPS_PIN_SUSP_LOW) :
                      cfg.eeprom_mode ? SRPS_PIN_I2C : SRPS_PIN_SPI;

    wire mode_reset = (pin_mode == SRPS_PIN_RESET);
    wire mode_spi = (pin_mode == SRPS_PIN_SPI);
    wire mode_i2c = (pin_mode == SRPS_PIN_I2C);
    wire mode_low = (pin_mode == SRPS_PIN_SUSP_LOW);

    // Pull-down only while the strap is being presented.
    assign data_pin_pulldown = mode_reset;

    // Pad driver per mode; reset and fast-strap suspend float the pad.
    assign data_pin.oe = mode_spi | mode_low | (mode_i2c & eeprom_sda_low);
    assign data_pin.out = mode_spi ? link_dout : 1'b0;

    // The synchronised pad level is the EEPROM data seen by the I2C engine.
    assign eeprom_serial_data = pad_s;

    // Data-in pad keeps its weak pull-down at all times.
    assign rom_data_in_pulldown = 1'b1;

    // ROM clock is forced low while reset is asserted.
    assign rom_clock = link_sclk & ~reset & mode_spi;

    // A byte is accepted only in serial ROM operation with no byte in flight.
    assign tx_ready = ~busy & mode_spi;

    wire tx_take = tx_valid & tx_ready;
    wire link_done = ack_s ^ ack_seen;

    // Byte handshake: data held stable, request toggled, ack returns answer.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            busy <= 1'b0;
            req_toggle <= 1'b0;
            ack_seen <= 1'b0;
            tx_hold <= '0;
            rx_valid <= 1'b0;
            rx_data <= '0;
        end
        else
        begin
            rx_valid <= link_done;
            if (link_done)
            begin
                ack_seen <= ack_s;
                rx_data <= link_rx;
                busy <= 1'b0;
            end
            else if (tx_take)
            begin
                tx_hold <= tx_data;
                req_toggle <= ~req_toggle;
                busy <= 1'b1;
            end
        end
    end

    wire next_select_n = ~(mode_spi & (cfg.select_req | busy));

    // Select is high in reset and power-down, low while the ROM is addressed.
    always_ff @(posedge clk)
    begin
        if (reset)
            rom_select_n <= 1'b1;
        else
            rom_select_n <= next_select_n;
    end

    // General purpose pad is a plain output; card power FET follows its field.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            general_output_pin <= 1'b0;
            card_power_fet <= '0;
            card_power_drive <= 1'b0;
        end
        else
        begin
            general_output_pin <= gpo_value;
            card_power_fet <= card_power_config[`SRPS_CARD_PWR_MSB:`SRPS_CARD_PWR_LSB];
            card_power_drive <= |card_power_config[`SRPS_CARD_PWR_MSB:`SRPS_CARD_PWR_LSB];
        end
    end

    // Bit engine on the link clock.
    srps_link_shift #(.BYTE_W(BYTE_W)) u_link (
        .link_clk(link_clk),
        .link_reset(link_reset),
        .req_toggle(req_toggle),
        .tx_data(tx_hold),
        .rom_data_in(rom_data_in),
        .ack_toggle(link_ack),
        .rx_data(link_rx),
        .link_sclk(link_sclk),
        .link_dout(link_dout)
    );
endmodule : srps_rom_port

// ==== logic/srps_sync.sv ====
/*
 * Two-flop synchroniser for single-bit levels, one per bit of WIDTH.
 * Assumes each input bit is a level that is held for several cycles.
 */
module srps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // Data flops carry no reset so they track the pad through reset.
    always_ff @(posedge clk)
    begin
        meta <= d;
        q <= meta;
    end
endmodule : srps_sync

// ==== tb/srps_rom_model.sv ====
/* Serial ROM model: takes a byte MSB first and returns the byte before it.
   Assumes the clock rests low between frames. */
module srps_rom_model #(
    parameter logic [7:0] FIRST = 8'hc3
) (
    input wire logic rom_clock,
    input wire logic rom_select_n,
    input srps_pkg::srps_pin_t data_pin,
    output logic rom_data_in,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    import srps_pkg::*;
    logic [7:0] shift_in = 8'h00;
    logic [7:0] reply = FIRST;
    logic [2:0] bit_idx = 3'h0;
    // Take the command bit on each rising clock.
    always @(posedge rom_clock)
        if (rom_select_n === 1'b0)
            shift_in <= {shift_in[6:0], data_pin.out};
    // Next reply bit on each falling clock; the eighth one ends the byte.
    always @(negedge rom_clock or posedge rom_select_n)
        if (rom_select_n !== 1'b0)
            bit_idx <= 3'h0;
        else
        begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7)
            begin
                got <= shift_in;
                reply <= shift_in;
            end
        end
    // Deselected, the pull-down holds the line low.
    assign rom_data_in = rom_select_n ? 1'b0 : reply[3'h7 - bit_idx];
endmodule : srps_rom_model

// ==== tb/srps_rom_port_properties.sv ====
/* Checker on the serial ROM port pads, strap latch and ROM select.
   Assumes a bind into srps_rom_port on its single clk domain. */
module srps_rom_port_properties (
    input wire logic clk,
    input wire logic reset,
    input srps_pkg::srps_port_cfg_t cfg,
    input wire logic rom_speed_strap,
    input srps_pkg::srps_pin_t data_pin,
    input wire logic data_pin_pulldown,
    input wire logic eeprom_sda_low,
    input wire logic rom_data_in_pulldown,
    input wire logic rom_clock,
    input wire logic rom_select_n,
    input wire logic rom_speed_fast,
    input wire logic strap_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    import srps_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    // Reset released after the pad was steady for four cycles.
    sequence s_strap_take;
        $stable(rom_speed_strap) [*4] ##0 ($past(reset) && !reset);
    endsequence
    // Normal running outside reset and suspend.
    wire logic run = !reset && strap_valid && !cfg.suspend;
    // Pad, latch, select and clock relations.
    AST_RST_FLOAT: assert property (reset && $past(reset)
        |-> !data_pin.oe && data_pin_pulldown) else $error("pad driven in reset");
    AST_STRAP_TAKE: assert property (s_strap_take
        |=> strap_valid && rom_speed_fast == $past(rom_speed_strap)) else $error("bad strap");
    AST_PAD_OUT: assert property (disable iff (reset) run && !cfg.eeprom_mode
        |-> data_pin.oe && !data_pin_pulldown) else $error("pad not driving");
    AST_SUSP_FLOAT: assert property (disable iff (reset) strap_valid && cfg.suspend
        && rom_speed_fast |-> !data_pin.oe) else $error("pad driven in suspend");
    AST_SUSP_LOW: assert property (disable iff (reset) strap_valid && cfg.suspend
        && !rom_speed_fast |-> data_pin.oe && !data_pin.out) else $error("pad not low");
    AST_EEPROM_OD: assert property (disable iff (reset) run && cfg.eeprom_mode
        |-> data_pin.oe == eeprom_sda_low && !(data_pin.oe && data_pin.out)) else $error("bad sda");
    AST_DI_PULL: assert property (rom_data_in_pulldown)
        else $error("data-in pull-down off");
    AST_SEL_SUSP: assert property (disable iff (reset) cfg.suspend [*2]
        |-> rom_select_n) else $error("select low in suspend");
    AST_CLK_RST: assert property (reset |-> !rom_clock)
        else $error("ROM clock high in reset");
    AST_STRAP_HOLD: assert property (disable iff (reset) strap_valid
        |=> strap_valid && $stable(rom_speed_fast)) else $error("strap latch moved");
endmodule : srps_rom_port_properties
bind srps_rom_port srps_rom_port_properties srps_rom_port_properties_i (
    .clk, .reset, .cfg, .rom_speed_strap, .data_pin, .data_pin_pulldown, .eeprom_sda_low,
    .rom_data_in_pulldown, .rom_clock, .rom_select_n, .rom_speed_fast, .strap_valid
);

// ==== tb/srps_rom_port_test.sv ====
/* Self-checking bench for srps_rom_port with a serial ROM model.
   Assumes design, checker and model are compiled before it. */
`include "srps_defs.svh"
module srps_rom_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import srps_pkg::*;
    logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, tx_valid = 1'b0, eeprom_sda_low = 1'b0;
    logic gpo_value = 1'b0, strap_level = 1'b0;
    srps_port_cfg_t cfg = '0;
    srps_byte_t tx_data = 8'h00, card_power_config = 8'h00, last_sent = 8'hc3;
    int n_fail = 0, n_tests = 0;
    wire logic tx_ready, rx_valid, eeprom_serial_data, rom_speed_strap, data_pin_pulldown;
    wire logic rom_data_in, rom_data_in_pulldown, rom_clock, rom_select_n, rom_speed_fast;
    wire logic strap_valid, general_output_pin, card_power_drive;
    wire srps_byte_t rx_data, got;
    wire logic [`SRPS_CARD_PWR_W-1:0] card_power_fet;
    wire srps_pin_t data_pin;
    // The pad shows its driver when enabled, else the board strap resistor.
    assign rom_speed_strap = data_pin.oe ? data_pin.out : strap_level;
    // Core clock and an unrelated link clock.
    initial forever #4 clk = ~clk;
    initial
    begin
        #5;
        forever #32 link_clk = ~link_clk;
    end
    // The block and the ROM on its far side.
    srps_rom_port srps_rom_port_i (
        .clk, .reset, .link_clk, .cfg, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data,
        .eeprom_sda_low, .eeprom_serial_data, .rom_speed_strap, .data_pin, .data_pin_pulldown,
        .rom_data_in, .rom_data_in_pulldown, .rom_clock, .rom_select_n, .rom_speed_fast,
        .strap_valid, .gpo_value, .general_output_pin, .card_power_config, .card_power_fet,
        .card_power_drive
    );
    srps_rom_model srps_rom_model_i (.rom_clock, .rom_select_n, .data_pin, .rom_data_in, .got);
    // Compares a value and counts the outcome.
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        n_tests++;
        if (a !== e)
            $display("BAD %0t got %h want %h", $time, a, e);
        n_fail += (a !== e);
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Cycle ceiling far above the expected run of some 700 cycles.
    initial
    begin
        repeat (6000) @(posedge clk);
        n_fail++;
        stop_test();
    end
    // Pad state in reset, then the strap capture at release.
    task automatic test_reset(input logic s);
        logic [7:0] v;
        @(posedge clk);
        reset <= 1'b1;
        strap_level <= s;
        repeat (`SRPS_RESET_MIN_CYC) @(posedge clk);
        @(negedge clk);
        v = {3'h0, data_pin.oe, data_pin_pulldown, rom_clock, strap_valid, rom_select_n};
        chk(v, 8'h09);
        @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(negedge clk);
        v = {4'h0, strap_valid, rom_speed_fast, data_pin.oe, data_pin_pulldown};
        chk(v, {4'h0, 1'b1, s, 2'b10});
        $display("reset test done, strap %b", s);
    endtask : test_reset
    // Suspend pad use by strap with a select request pending; the latch holds.
    // Once suspend ends, the pending request must pull the ROM select low.
    task automatic test_suspend(input logic s);
        logic [7:0] v;
        @(posedge clk);
        strap_level <= ~s;
        cfg.suspend <= 1'b1;
        cfg.select_req <= 1'b1;
        repeat (6) @(negedge clk);
        v = {3'h0, data_pin.oe, data_pin.oe & data_pin.out, rom_select_n, rom_speed_fast, tx_ready};
        chk(v, {3'h0, ~s, 1'b0, 1'b1, s, 1'b0});
        @(posedge clk);
        cfg.suspend <= 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, rom_select_n}, 8'h00);
        @(posedge clk);
        cfg.select_req <= 1'b0;
        $display("suspend test done, strap %b", s);
    endtask : test_suspend
    // Open-drain data line in EEPROM mode, read back through the pad.
    task automatic test_eeprom();
        logic [7:0] v;
        @(posedge clk);
        cfg.eeprom_mode <= 1'b1;
        strap_level <= 1'b1;
        for (int i = 1; i >= 0; i--)
        begin
            eeprom_sda_low <= i[0];
            repeat (4) @(negedge clk);
            v = {5'h0, tx_ready, data_pin.oe, eeprom_serial_data};
            chk(v, {6'h0, i[0], ~i[0]});
            @(posedge clk);
        end
        cfg.eeprom_mode <= 1'b0;
        $display("eeprom test done");
    endtask : test_eeprom
    // One byte out MSB first and one back; the ROM echoes the byte before.
    task automatic test_byte(input srps_byte_t b);
        int n;
        @(posedge clk);
        tx_data <= b;
        tx_valid <= 1'b1;
        @(negedge clk);
        for (n = 0; n < 50 && tx_ready !== 1'b1; n++)
            @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b0;
        for (n = 0; n < 500 && rx_valid !== 1'b1; n++)
            @(negedge clk);
        chk(rx_data, last_sent);
        chk(got, b);
        @(negedge clk);
        chk({7'h0, rx_valid}, 8'h00);
        last_sent = b;
        $display("byte test done, %h", b);
    endtask : test_byte
    // General output and card power follow their inputs.
    task automatic test_side(input srps_byte_t c);
        logic [7:0] v;
        @(posedge clk);
        card_power_config <= c;
        gpo_value <= c[7];
        repeat (2) @(negedge clk);
        v = {general_output_pin, 2'h0, card_power_drive, card_power_fet};
        chk(v, {c[7], 2'h0, |c[3:0], c[3:0]});
        $display("side test done, %h", c);
    endtask : test_side
    // Main sequence.
    initial
    begin
        test_reset(1'b1);
        test_suspend(1'b1);
        test_reset(1'b0);
        test_suspend(1'b0);
        test_eeprom();
        test_byte(8'ha6);
        test_byte(8'h3c);
        test_side(8'h5a);
        test_side(8'h80);
        stop_test();
    end
endmodule : srps_rom_port_test
